// File: core/i2c_host_ctrl.sv
`timescale 1ns/10ps
module i2c_host_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  i2c_link_if.host         link,
  input  wire logic [3:0]  adr_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o
);

  typedef enum logic [1:0] {
    H_IDLE,
    H_START,
    H_STOP,
    H_BITS
  } host_state_t;

  typedef struct packed {
    logic [1:0]  sy;
    host_state_t fsm;
    logic [6:0]  tick;
    logic [2:0]  ph;
    logic [3:0]  nbit;
    logic [8:0]  sh;
    logic [7:0]  txd;
    logic [7:0]  rxd;
    logic        nack;
    logic        scl_oe;
    logic        sda_oe;
    logic        ack;
    logic [7:0]  dat;
  } host_t;

  host_t r;
  host_t n;

  logic       req;
  logic       wr;
  logic       step;
  logic       sda;
  logic [2:0] cmd;

  assign sda  = r.sy[1];
  assign req  = cyc_i & stb_i & ~r.ack;
  assign wr   = cyc_i & stb_i & we_i & r.ack & sel_i[0];
  assign step = (r.tick == pmic_pkg::TICK_CYC - 7'h1);
  assign cmd  = dat_i[2:0];

  always_comb begin
    n     = r;
    n.sy  = {r.sy[0], link.sda};
    n.ack = req;
    if (req) begin
      unique case (adr_i)
        pmic_pkg::HOST_TXD:  n.dat = r.txd;
        pmic_pkg::HOST_RXD:  n.dat = r.rxd;
        pmic_pkg::HOST_STAT: n.dat = {6'h0, r.nack, r.fsm != H_IDLE};
        default:             n.dat = 8'h00;
      endcase
    end
    if (wr && adr_i == pmic_pkg::HOST_TXD) begin
      n.txd = dat_i[7:0];
    end
    // A command written while busy is dropped; software polls the busy bit first.
    if (wr && adr_i == pmic_pkg::HOST_CMD && r.fsm == H_IDLE) begin
      n.tick = 7'h0;
      n.ph   = 3'h0;
      n.nbit = 4'h0;
      if (cmd == pmic_pkg::CMD_START) begin
        n.fsm = H_START;
      end else if (cmd == pmic_pkg::CMD_STOP) begin
        n.fsm = H_STOP;
      end else if (cmd == pmic_pkg::CMD_WRITE) begin
        n.fsm = H_BITS;
        n.sh  = {r.txd, 1'b1};
      end else if (cmd == pmic_pkg::CMD_READ) begin
        n.fsm = H_BITS;
        n.sh  = {8'hff, dat_i[pmic_pkg::CMD_NACK_BIT]}; // [RULE8]
      end
    end
    if (r.fsm != H_IDLE) begin
      // Five ticks of 650 ns per bit keep the clock below 400 kHz with margin.
      n.tick = step ? 7'h0 : r.tick + 7'h1; // [RULE2]
      if (step) begin
        n.ph = (r.ph == pmic_pkg::LAST_PHASE) ? 3'h0 : r.ph + 3'h1;
        unique case (r.fsm)
          H_START: begin
            if (r.ph == 3'h0) n.sda_oe = 1'b0;
            if (r.ph == 3'h1) n.scl_oe = 1'b0;
            if (r.ph == 3'h2) n.sda_oe = 1'b1; // [RULE5]
            if (r.ph == 3'h3) begin
              n.scl_oe = 1'b1;
              n.fsm    = H_IDLE;
            end
          end
          H_STOP: begin
            if (r.ph == 3'h0) n.sda_oe = 1'b1;
            if (r.ph == 3'h1) n.scl_oe = 1'b0;
            if (r.ph == 3'h2) n.sda_oe = 1'b0; // [RULE5]
            if (r.ph == pmic_pkg::LAST_PHASE) n.fsm = H_IDLE;
          end
          H_BITS: begin
            if (r.ph == 3'h0) n.sda_oe = ~r.sh[8]; // [RULE4]
            if (r.ph == 3'h2) n.scl_oe = 1'b0;
            if (r.ph == pmic_pkg::LAST_PHASE) begin
              n.sh     = {r.sh[7:0], sda};
              n.scl_oe = 1'b1;
              n.nbit   = r.nbit + 4'h1;
              if (r.nbit == pmic_pkg::LAST_BIT) begin // [RULE7]
                n.rxd  = r.sh[7:0];
                n.nack = sda;
                n.fsm  = H_IDLE;
              end
            end
          end
          default: n.fsm = H_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r    <= '0;
      r.sy <= 2'h3;
    end else begin
      r <= n;
    end
  end

  assign link.scl_out_h = 1'b0;
  assign link.sda_out_h = 1'b0;
  assign link.scl_oe_h  = r.scl_oe;
  assign link.sda_oe_h  = r.sda_oe;
  assign dat_o          = {24'h0, r.dat};
  assign ack_o          = r.ack;

endmodule : i2c_host_ctrl

// File: core/i2c_link_if.sv
`timescale 1ns/10ps
interface i2c_link_if;
  logic scl_out_h;
  logic scl_oe_h;
  logic sda_out_h;
  logic sda_oe_h;
  logic sda_out_t;
  logic sda_oe_t;
  logic scl;
  logic sda;

  // Both lines are open drain with a pull-up; any enabled driver wins low.
  assign scl = scl_oe_h ? scl_out_h : 1'b1;
  assign sda = (sda_oe_h ? sda_out_h : 1'b1) & (sda_oe_t ? sda_out_t : 1'b1);

  modport host (output scl_out_h, scl_oe_h, sda_out_h, sda_oe_h, input scl, sda);
  modport target (output sda_out_t, sda_oe_t, input scl, sda);
endinterface : i2c_link_if

// File: core/pmic_pkg.sv
// What this block does
// [RULE1] Answer only at bus address 1001000.
// [RULE2] Standard and fast mode, up to 400 kHz.
// [RULE3] Unmapped register reads return 00h.
// [RULE4] Data changes only while clock low.
// [RULE5] Master frames transfers with start and stop.
// [RULE6] Target acknowledges every byte once addressed.
// [RULE7] Master gives an extra acknowledge clock pulse.
// [RULE8] Master withholds last read ack; target releases.
// [RULE9] Undervoltage lockout reloads every register default.
// [RULE10] Optional long button press resets registers.
// [RULE11] Bits 7 and 6 show source presence.
// [RULE12] Bit 5 set suspends the USB input.
// [RULE13] Bit 4 set disables the adapter input.
// [RULE14] Bits 3..2 select adapter current limit.
// [RULE15] Bits 1..0 select USB current limit.
// [RULE16] Safety timers clear with both inputs absent.
// [RULE17] Defaults on lockout and source removal.
package pmic_pkg;
  localparam logic [6:0]  DEV_ADDR       = 7'h48;
  localparam logic [7:0]  PPC_OFFSET     = 8'h01;
  localparam logic [7:0]  UNMAPPED_READ  = 8'h00;
  localparam int          USB_VALID_BIT  = 7;
  localparam int          ADP_VALID_BIT  = 6;
  localparam int          USB_DIS_BIT    = 5;
  localparam int          ADP_DIS_BIT    = 4;
  localparam int          ADP_LIM_LSB    = 2;
  localparam int          USB_LIM_LSB    = 0;
  localparam logic        USB_DIS_RST    = 1'h0;
  localparam logic        ADP_DIS_RST    = 1'h0;
  localparam logic [1:0]  ADP_LIM_RST    = 2'h3;
  localparam logic [1:0]  USB_LIM_RST    = 2'h1;
  localparam logic [3:0]  BYTE_BITS      = 4'h8;
  localparam int          CLK_NS         = 10;
  localparam longint      PRESS_MS       = 15000;
  localparam longint      PRESS_CYC      = PRESS_MS * 64'd1000000 / CLK_NS;
  localparam int          SCL_MAX_KHZ    = 400;
  localparam int          TICK_NS        = 650;
  localparam logic [6:0]  TICK_CYC       = 7'((TICK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0]  LAST_PHASE     = 3'h4;
  localparam logic [3:0]  LAST_BIT       = 4'h8;
  localparam logic [3:0]  HOST_CMD       = 4'h0;
  localparam logic [3:0]  HOST_TXD       = 4'h4;
  localparam logic [3:0]  HOST_RXD       = 4'h8;
  localparam logic [3:0]  HOST_STAT      = 4'hc;
  localparam logic [2:0]  CMD_START      = 3'h1;
  localparam logic [2:0]  CMD_STOP       = 3'h2;
  localparam logic [2:0]  CMD_WRITE      = 3'h3;
  localparam logic [2:0]  CMD_READ       = 3'h4;
  localparam int          CMD_NACK_BIT   = 3;
endpackage : pmic_pkg

// File: core/pmic_target.sv
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/10ps
module pmic_target #(
  parameter int unsigned PRESS_CYCLES = 32'(pmic_pkg::PRESS_CYC)
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  i2c_link_if.target      link,
  input  wire logic       undervoltage_lockout_i,
  input  wire logic       push_button_input_n_i,
  input  wire logic       long_press_enable_i,
  input  wire logic       usb_valid_i,
  input  wire logic       adapter_valid_i,
  output logic            usb_input_disable_o,
  output logic            adapter_input_disable_o,
  output logic [1:0]      adapter_current_limit_o,
  output logic [1:0]      usb_current_limit_o,
  output logic            safety_timer_clear_o
);

  typedef enum logic [2:0] {
    T_IDLE,
    T_ADDR,
    T_WR,
    T_ACK_WR,
    T_ACK_RD,
    T_RD,
    T_MACK
  } tgt_state_t;

  typedef struct packed {
    logic [6:0]  s1;
    logic [6:0]  s2;
    logic        scl_d;
    logic        sda_d;
    tgt_state_t  fsm;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic        first;
    logic        mack;
    logic [7:0]  ptr;
    logic        oe;
    logic        usb_d;
    logic        adp_d;
    logic        usb_dis;
    logic        adp_dis;
    logic [1:0]  adp_lim;
    logic [1:0]  usb_lim;
    logic [31:0] press;
    logic        tclr;
  } tgt_t;

  tgt_t r;
  tgt_t n;

  logic scl;
  logic sda;
  logic undervoltage_lockout;
  logic pb_n;
  logic lp_en;
  logic usb_ok;
  logic adp_ok;
  logic rise;
  logic fall;
  logic start_seen;
  logic stop_seen;
  logic long_press;
  logic [7:0] nxt_ptr;

  // Every pin is from outside this clock and is read only after the second flop.
  assign scl        = r.s2[6];
  assign sda        = r.s2[5];
  assign undervoltage_lockout       = r.s2[4];
  assign pb_n       = r.s2[3];
  assign lp_en      = r.s2[2];
  assign usb_ok     = r.s2[1];
  assign adp_ok     = r.s2[0];
  assign rise       = scl & ~r.scl_d;
  assign fall       = ~scl & r.scl_d;
  assign start_seen = scl & r.scl_d & r.sda_d & ~sda; // [RULE4] [RULE5]
  assign stop_seen  = scl & r.scl_d & ~r.sda_d & sda; // [RULE4] [RULE5]
  assign long_press = (r.press == PRESS_CYCLES);
  assign nxt_ptr    = r.ptr + 8'h01;

  function automatic logic [7:0] read_byte(input tgt_t q, input logic [7:0] addr);
    logic [7:0] v;
    v = pmic_pkg::UNMAPPED_READ; // [RULE3]
    if (addr == pmic_pkg::PPC_OFFSET) begin
      v[pmic_pkg::USB_VALID_BIT]                   = q.s2[1]; // [RULE11]
      v[pmic_pkg::ADP_VALID_BIT]                   = q.s2[0]; // [RULE11]
      v[pmic_pkg::USB_DIS_BIT]                     = q.usb_dis;
      v[pmic_pkg::ADP_DIS_BIT]                     = q.adp_dis;
      v[pmic_pkg::ADP_LIM_LSB+1:pmic_pkg::ADP_LIM_LSB] = q.adp_lim;
      v[pmic_pkg::USB_LIM_LSB+1:pmic_pkg::USB_LIM_LSB] = q.usb_lim;
    end
    return v;
  endfunction : read_byte

  always_comb begin
    n       = r;
    n.s1    = {link.scl, link.sda, undervoltage_lockout_i, push_button_input_n_i,
               long_press_enable_i, usb_valid_i, adapter_valid_i};
    n.s2    = r.s1;
    n.scl_d = scl;
    n.sda_d = sda;

    if (stop_seen) begin
      n.fsm = T_IDLE;
      n.oe  = 1'b0;
    end else if (start_seen) begin
      n.fsm   = T_ADDR;
      n.cnt   = 4'h0;
      n.oe    = 1'b0;
      n.first = 1'b1;
    end else begin
      unique case (r.fsm)
        T_IDLE: begin
          n.oe = 1'b0;
        end
        T_ADDR, T_WR: begin
          if (rise) begin
            n.sh  = {r.sh[6:0], sda};
            n.cnt = r.cnt + 4'h1;
          end else if (fall && r.cnt == pmic_pkg::BYTE_BITS) begin
            n.cnt = 4'h0;
            if (r.fsm == T_ADDR) begin
              // A foreign address leaves the line alone until the next start.
              if (r.sh[7:1] == pmic_pkg::DEV_ADDR) begin // [RULE1]
                n.oe  = 1'b1; // [RULE6]
                n.fsm = r.sh[0] ? T_ACK_RD : T_ACK_WR;
              end else begin
                n.fsm = T_IDLE;
              end
            end else begin
              n.oe    = 1'b1; // [RULE6]
              n.fsm   = T_ACK_WR;
              n.first = 1'b0;
              if (r.first) begin
                n.ptr = r.sh;
              end else begin
                n.ptr = nxt_ptr;
                if (r.ptr == pmic_pkg::PPC_OFFSET) begin
                  n.usb_dis = r.sh[pmic_pkg::USB_DIS_BIT]; // [RULE12]
                  n.adp_dis = r.sh[pmic_pkg::ADP_DIS_BIT]; // [RULE13]
                  n.adp_lim = r.sh[pmic_pkg::ADP_LIM_LSB+1:pmic_pkg::ADP_LIM_LSB]; // [RULE14]
                  n.usb_lim = r.sh[pmic_pkg::USB_LIM_LSB+1:pmic_pkg::USB_LIM_LSB]; // [RULE15]
                end
              end
            end
          end
        end
        T_ACK_WR: begin
          // The low is held from one falling edge to the next, so it spans the high phase.
          if (fall) begin // [RULE6] [RULE7]
            n.oe  = 1'b0;
            n.fsm = T_WR;
          end
        end
        T_ACK_RD: begin
          if (fall) begin // [RULE7]
            n.sh  = read_byte(r, r.ptr);
            n.oe  = ~n.sh[7]; // [RULE4]
            n.cnt = 4'h0;
            n.fsm = T_RD;
          end
        end
        T_RD: begin
          if (rise) begin
            n.cnt = r.cnt + 4'h1;
          end else if (fall) begin
            if (r.cnt == pmic_pkg::BYTE_BITS) begin
              n.oe  = 1'b0;
              n.cnt = 4'h0;
              n.fsm = T_MACK;
            end else begin
              n.oe = ~r.sh[6]; // [RULE4]
              n.sh = {r.sh[6:0], 1'b0};
            end
          end
        end
        T_MACK: begin
          if (rise) begin
            n.mack = sda; // [RULE7]
          end else if (fall) begin
            if (!r.mack) begin
              n.ptr = nxt_ptr;
              n.sh  = read_byte(r, nxt_ptr);
              n.oe  = ~n.sh[7];
              n.cnt = 4'h0;
              n.fsm = T_RD;
            end else begin
              // Without an acknowledge the line stays released for the stop.
              n.oe  = 1'b0; // [RULE8]
              n.fsm = T_IDLE;
            end
          end
        end
      endcase
    end

    n.usb_d = usb_ok;
    n.adp_d = adp_ok;
    if (r.adp_d && !adp_ok) begin
      n.adp_lim = pmic_pkg::ADP_LIM_RST; // [RULE17]
    end
    if (r.usb_d && !usb_ok) begin
      n.usb_lim = pmic_pkg::USB_LIM_RST; // [RULE17]
    end

    // The counter saturates, so a button held past the limit keeps the defaults loaded.
    if (pb_n || !lp_en) begin
      n.press = 32'h0;
    end else if (!long_press) begin
      n.press = r.press + 32'h1; // [RULE10]
    end

    if (undervoltage_lockout || long_press) begin // [RULE9] [RULE10]
      n.usb_dis = pmic_pkg::USB_DIS_RST; // [RULE17]
      n.adp_dis = pmic_pkg::ADP_DIS_RST; // [RULE17]
      n.adp_lim = pmic_pkg::ADP_LIM_RST; // [RULE17]
      n.usb_lim = pmic_pkg::USB_LIM_RST; // [RULE17]
    end

    n.tclr = ~usb_ok & ~adp_ok; // [RULE16]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r         <= '0;
      // Sync flops start at the idle pin levels, so leaving reset shows no false line edge.
      r.s1      <= 7'h68;
      r.s2      <= 7'h68;
      r.scl_d   <= 1'b1;
      r.sda_d   <= 1'b1;
      r.usb_dis <= pmic_pkg::USB_DIS_RST;
      r.adp_dis <= pmic_pkg::ADP_DIS_RST;
      r.adp_lim <= pmic_pkg::ADP_LIM_RST;
      r.usb_lim <= pmic_pkg::USB_LIM_RST;
    end else begin
      r <= n;
    end
  end

  assign link.sda_out_t          = 1'b0;
  assign link.sda_oe_t           = r.oe;
  assign usb_input_disable_o     = r.usb_dis;
  assign adapter_input_disable_o = r.adp_dis;
  assign adapter_current_limit_o = r.adp_lim;
  assign usb_current_limit_o     = r.usb_lim;
  assign safety_timer_clear_o    = r.tclr;

endmodule : pmic_target

// File: tb/pmic_checker.sv
`timescale 1ns/10ps
module pmic_checker (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic scl_oe_h,
  input  wire logic sda_oe_h,
  input  wire logic sda_oe_t,
  input  wire logic scl,
  input  wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic       busy_r;
  logic [7:0] hi_r;
  logic [7:0] lo_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A data edge while the clock stays high is a start (fall) or a stop (rise).
  always_ff @(posedge clk_i) begin
    scl_q <= scl;
    sda_q <= sda;
    if (rst_i) begin
      busy_r <= 1'b0;
      hi_r   <= 8'h00;
      lo_r   <= 8'h00;
    end else begin
      if (scl && scl_q && sda != sda_q) begin
        busy_r <= sda_q;
      end
      hi_r <= !scl ? 8'h00 : (hi_r == 8'hff ? hi_r : hi_r + 8'h01);
      lo_r <= scl ? 8'h00 : (lo_r == 8'hff ? lo_r : lo_r + 8'h01);
    end
  end
  property p_tgt_hold; scl && scl_q |-> $stable(sda_oe_t); endproperty
  a_tgt_hold: assert property (p_tgt_hold)
    else $error("target moved data while clock high");
  property p_no_false_start; scl && scl_q && !sda && sda_q |-> !sda_oe_t; endproperty
  a_no_false_start: assert property (p_no_false_start)
    else $error("target made a start edge");
  property p_ack_hold; $rose(scl) && sda_oe_t |-> sda_oe_t [*8]; endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("target low level not held over clock high");
  property p_stop_release;
    scl && scl_q && sda && !sda_q |-> !sda_oe_t && !$past(sda_oe_t, 2);
  endproperty
  a_stop_release: assert property (p_stop_release)
    else $error("target held data at stop");
  property p_idle_release; !busy_r |-> !sda_oe_t; endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("target drove data outside a frame");
  property p_high_time; $fell(scl) |-> hi_r >= 8'h3c; endproperty
  a_high_time: assert property (p_high_time)
    else $error("clock high time too short");
  property p_low_time; $fell(scl) |-> !scl [*8]; endproperty
  a_low_time: assert property (p_low_time)
    else $error("clock low time too short");
  property p_clk_in_frame; $rose(scl) |-> busy_r; endproperty
  a_clk_in_frame: assert property (p_clk_in_frame)
    else $error("clock pulse outside a frame");
  // The short repetition above only catches glitches; the counter checks the full low time.
  property p_low_count; $rose(scl) |-> lo_r >= 8'h82; endproperty
  a_low_count: assert property (p_low_count)
    else $error("clock low time below minimum");
  property p_host_clk_idle; !busy_r |-> !scl_oe_h; endproperty
  a_host_clk_idle: assert property (p_host_clk_idle)
    else $error("host held clock low outside a frame");
  property p_host_data_hold; $rose(scl) |-> $stable(sda_oe_h) [*8]; endproperty
  a_host_data_hold: assert property (p_host_data_hold)
    else $error("host moved data early in clock high");
  c_ack: cover property ($rose(scl) && sda_oe_t);
  c_start: cover property (scl && scl_q && !sda && sda_q);
  c_stop: cover property (scl && scl_q && sda && !sda_q);
endmodule : pmic_checker

// File: tb/pmic_i2c_target_power_path_reg_bench.sv
`timescale 1ns/10ps
module pmic_i2c_target_power_path_reg_bench;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic [3:0]  adr     = 4'h0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [31:0] wdat    = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        undervoltage_lockout    = 1'b0;
  logic        pb_n    = 1'b1;
  logic        lp_en   = 1'b0;
  logic        usb_ok  = 1'b0;
  logic        adp_ok  = 1'b0;
  logic        usb_dis;
  logic        adp_dis;
  logic [1:0]  adp_lim;
  logic [1:0]  usb_lim;
  logic        tmr_clr;
  logic [31:0] q;
  logic [7:0]  b;
  logic [7:0]  b2;
  int          fails     = 0;
  int          tests_run = 0;
  i2c_link_if link ();
  // A short press count keeps the long-press case inside the run length.
  pmic_target #(.PRESS_CYCLES(100)) i_pmic_target (.clk_i(clk_i), .rst_i(rst_i),
    .link(link), .undervoltage_lockout_i(undervoltage_lockout), .push_button_input_n_i(pb_n),
    .long_press_enable_i(lp_en), .usb_valid_i(usb_ok), .adapter_valid_i(adp_ok),
    .usb_input_disable_o(usb_dis), .adapter_input_disable_o(adp_dis),
    .adapter_current_limit_o(adp_lim), .usb_current_limit_o(usb_lim),
    .safety_timer_clear_o(tmr_clr));
  i2c_host_ctrl i_i2c_host_ctrl (.clk_i(clk_i), .rst_i(rst_i), .link(link), .adr_i(adr),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack));
  pmic_checker i_pmic_checker (.clk_i(clk_i), .rst_i(rst_i), .scl_oe_h(link.scl_oe_h),
    .sda_oe_h(link.sda_oe_h), .sda_oe_t(link.sda_oe_t), .scl(link.scl), .sda(link.sda));
  always #5 clk_i = ~clk_i;

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task automatic hang();
    fails++;
    wrap_up();
  endtask : hang

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic out(input logic [7:0] e);
    repeat (8) @(posedge clk_i);
    chk("power path outputs", e, {2'b00, usb_dis, adp_dis, adp_lim, usb_lim});
  endtask : out

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) hang();
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic cmd(input logic [3:0] c);
    int n;
    wb(1'b1, pmic_pkg::HOST_CMD, {28'h0, c});
    n = 0;
    do begin
      wb(1'b0, pmic_pkg::HOST_STAT, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 4000);
    if (q[0] !== 1'b0) hang();
  endtask : cmd

  task automatic xb(input logic [7:0] d, input logic nak);
    wb(1'b1, pmic_pkg::HOST_TXD, {24'h0, d});
    cmd({1'b0, pmic_pkg::CMD_WRITE});
    chk("ack bit", {7'h0, nak}, {7'h0, q[1]});
  endtask : xb

  task automatic reg_wr(input logic [7:0] p, input logic [7:0] d);
    cmd({1'b0, pmic_pkg::CMD_START});
    xb(8'h90, 1'b0);
    xb(p, 1'b0);
    xb(d, 1'b0);
    cmd({1'b0, pmic_pkg::CMD_STOP});
  endtask : reg_wr

  // With two set, the byte at p lands in b2 and the next one, reached by the pointer's
  // own increment after the master's acknowledge, in b.
  task automatic reg_rd(input logic [7:0] p, input logic two);
    cmd({1'b0, pmic_pkg::CMD_START});
    xb(8'h90, 1'b0);
    xb(p, 1'b0);
    cmd({1'b0, pmic_pkg::CMD_START});
    xb(8'h91, 1'b0);
    if (two) begin
      cmd({1'b0, pmic_pkg::CMD_READ});
      wb(1'b0, pmic_pkg::HOST_RXD, 32'h0);
      b2 = q[7:0];
    end
    cmd({1'b1, pmic_pkg::CMD_READ});
    wb(1'b0, pmic_pkg::HOST_RXD, 32'h0);
    b = q[7:0];
    cmd({1'b0, pmic_pkg::CMD_STOP});
  endtask : reg_rd

  task automatic t_defaults();
    out(8'h0d);
    chk("timer clear", 8'h01, {7'h0, tmr_clr});
    usb_ok <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("timer clear", 8'h00, {7'h0, tmr_clr});
    $display("defaults test done");
  endtask : t_defaults

  task automatic t_fields();
    logic [1:0] i;
    logic [7:0] v;
    for (int k = 0; k < 4; k++) begin
      i = k[1:0];
      v = {2'b00, i[0], i[1], ~i, i};
      adp_ok <= i[0];
      reg_wr(8'h01, v);
      out(v);
      if (i[0]) begin
        reg_rd(8'h01, i[1]);
        chk("register readback", {1'b1, i[0], v[5:0]}, i[1] ? b2 : b);
        if (i[1]) begin
          chk("byte after register", 8'h00, b);
        end
      end
    end
    reg_rd(8'h05, 1'b0);
    chk("unmapped read", 8'h00, b);
    $display("field test done");
  endtask : t_fields

  task automatic t_address();
    cmd({1'b0, pmic_pkg::CMD_START});
    xb(8'h92, 1'b1);
    cmd({1'b0, pmic_pkg::CMD_STOP});
    out(8'h33);
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped host register", 8'h00, q[7:0]);
    $display("address test done");
  endtask : t_address

  task automatic t_resets();
    usb_ok <= 1'b0;
    out(8'h31);
    adp_ok <= 1'b0;
    out(8'h3d);
    chk("timer clear", 8'h01, {7'h0, tmr_clr});
    // A long press with the option switched off must leave the register alone.
    pb_n <= 1'b0;
    repeat (120) @(posedge clk_i);
    pb_n <= 1'b1;
    out(8'h3d);
    lp_en <= 1'b1;
    pb_n  <= 1'b0;
    repeat (50) @(posedge clk_i);
    pb_n <= 1'b1;
    out(8'h3d);
    pb_n <= 1'b0;
    repeat (120) @(posedge clk_i);
    pb_n <= 1'b1;
    out(8'h0d);
    reg_wr(8'h01, 8'h32);
    out(8'h32);
    undervoltage_lockout <= 1'b1;
    out(8'h0d);
    undervoltage_lockout <= 1'b0;
    $display("reset sources test done");
  endtask : t_resets

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_defaults();
    t_fields();
    t_address();
    t_resets();
    wrap_up();
  end
endmodule : pmic_i2c_target_power_path_reg_bench
